//--- rtl/pbcr_map.svh
// register offsets, field positions and reset values of the power budget bank
`ifndef PBCR_MAP_SVH
`define PBCR_MAP_SVH
`define PBCR_OFF_CAP_HEADER 12'h280
`define PBCR_OFF_DATA_SELECT 12'h284
`define PBCR_OFF_DATA_WINDOW 12'h288
`define PBCR_OFF_SYSTEM_ALLOC 12'h28C
`define PBCR_OFF_VALUE_ARRAY 12'h300
`define PBCR_OFF_INIT_CTRL 12'h340
`define PBCR_VALUE_COUNT 10
`define PBCR_SEL_MAX 8'h09
`define PBCR_CAPABILITY_IDENTIFIER_LSB 0
`define PBCR_CAPABILITY_IDENTIFIER_MSB 15
`define PBCR_CAPABILITY_VERSION_LSB 16
`define PBCR_CAPABILITY_VERSION_MSB 19
`define PBCR_NEXT_CAPABILITY_POINTER_LSB 20
`define PBCR_NEXT_CAPABILITY_POINTER_MSB 31
`define PBCR_CAPABILITY_IDENTIFIER_POWER_BUDGET 16'h0004
`define PBCR_CAPABILITY_VERSION_ONE 4'h1
`define PBCR_HEADER_RESET 32'h00000000
`define PBCR_SELECT_RESET 8'h00
`define PBCR_RESP_OKAY 2'h0
`define PBCR_RESP_SLVERR 2'h2
`endif

//--- rtl/pbcr_pkg.sv
// types of the power budget capability register bank
`default_nettype none
package pbcr_pkg;
   typedef enum logic [1:0]
   {
      PBCR_WR_IDLE = 2'b00,
      PBCR_WR_RESP = 2'b01
   } pbcr_wr_state_t;
endpackage
`default_nettype wire

//--- rtl/pbcr_value_mem.sv
// ten word budget value memory, registered read, sticky through hot reset
`timescale 1ns/10ps
`default_nettype none
module pbcr_value_mem
#(
   parameter int DEPTH = 10,
   parameter int AW = 4
)
(
   input wire logic clk, // core clock
   input wire logic we, // write strobe
   input wire logic [AW-1:0] waddr, // write index
   input wire logic [31:0] wdata, // write word
   input wire logic [3:0] wstrb, // byte lanes
   input wire logic [AW-1:0] raddr, // read index
   output logic [31:0] rdata // registered read word
);
   logic [31:0] mem [DEPTH];
   // no reset at all: contents start undefined and survive hot reset
   always_ff @(posedge clk)
   begin
      if (we && (int'(waddr) < DEPTH))
      begin
         for (int b = 0; b < 4; b++)
         begin
            if (wstrb[b])
            begin
               mem[waddr][b*8 +: 8] <= wdata[b*8 +: 8];
            end
         end
      end
      if (int'(raddr) < DEPTH)
      begin
         rdata <= mem[raddr];
      end
      else
      begin
         rdata <= 32'h00000000;
      end
   end
endmodule
`default_nettype wire

//--- rtl/pbcr_regs.sv
// power budget capability register bank with axi4-lite slave
// Notes on behaviour
// - low header bits hold capability id, zero until loaded during eeprom init
// - header bits 19:16 hold version, zero until loaded during eeprom init
// - header, flag, values loadable during eeprom init
// - selector low byte picks value, resets zero
// - selector above nine reads data as zero
// - data window read-only, returns selected word
// - bit 0 flags budget already system allocated
// - ten value words from 0x300, undefined start
// - value writes accepted only while unlocked or during eeprom init
// - locked value writes discarded, contents kept
`timescale 1ns/10ps
`default_nettype none
`include "pbcr_map.svh"
module pbcr_regs
   import pbcr_pkg::*;
#(
   parameter int VALUE_COUNT = `PBCR_VALUE_COUNT
)
(
   input wire logic aclk, // core clock, 40 MHz
   input wire logic aresetn, // hot reset, sync, active low
   input wire logic fund_resetn, // fundamental reset, sync, active low
   input wire logic budget_value_unlock, // unlock level from switch control
   input wire logic eeprom_init, // eeprom initialiser owns write path
   input wire logic [11:0] awaddr, // write address
   input wire logic [2:0] awprot, // unused protection
   input wire logic awvalid, // write address valid
   output logic awready, // write address ready
   input wire logic [31:0] wdata, // write data
   input wire logic [3:0] wstrb, // write strobes
   input wire logic wvalid, // write data valid
   output logic wready, // write data ready
   output logic [1:0] bresp, // write response
   output logic bvalid, // write response valid
   input wire logic bready, // write response ready
   input wire logic [11:0] araddr, // read address
   input wire logic [2:0] arprot, // unused protection
   input wire logic arvalid, // read address valid
   output logic arready, // read address ready
   output logic [31:0] rdata, // read data
   output logic [1:0] rresp, // read response
   output logic rvalid, // read data valid
   input wire logic rready, // read data ready
   output logic system_allocated, // budget counted by system
   output logic [7:0] value_selector // current selector
);
   // ****************************************
   // state
   // ****************************************
   typedef struct packed
   {
      pbcr_wr_state_t wst;
      logic aw_held;
      logic w_held;
      logic [11:0] aw_addr;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic [1:0] bresp;
      logic bvalid;
      logic rd_wait;
      logic [11:0] rd_addr;
      logic [1:0] rresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [31:0] header;
      logic [7:0] selector;
      logic awready;
      logic wready;
      logic arready;
   } pbcr_state_t;

   // sticky part kept apart so hot reset leaves it alone
   typedef struct packed
   {
      logic sys_alloc;
   } pbcr_sticky_t;

   pbcr_state_t st;
   pbcr_state_t next_st;
   pbcr_sticky_t sk;
   pbcr_sticky_t next_sk;
   logic mem_we;
   logic [3:0] mem_waddr;
   logic [3:0] mem_raddr;
   logic [31:0] mem_rdata;

   function automatic logic is_value_addr(input logic [11:0] a);
      // only whole aligned words are mapped, like every other register
      return (a >= `PBCR_OFF_VALUE_ARRAY)
         && (a < `PBCR_OFF_VALUE_ARRAY + 12'(VALUE_COUNT * 4))
         && (a[1:0] == 2'b00);
   endfunction

   function automatic logic [3:0] value_index(input logic [11:0] a);
      logic [11:0] d;
      d = a - `PBCR_OFF_VALUE_ARRAY;
      return d[5:2];
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
      begin
         if (s[b])
         begin
            r[b*8 +: 8] = d[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // ****************************************
   // value memory
   // ****************************************
   pbcr_value_mem #(.DEPTH(VALUE_COUNT), .AW(4)) u_mem
   (
      .clk(aclk),
      .we(mem_we),
      .waddr(mem_waddr),
      .wdata(st.w_data),
      .wstrb(st.w_strb),
      .raddr(mem_raddr),
      .rdata(mem_rdata)
   );

   // ****************************************
   // next state
   // ****************************************
   always_comb
   begin
      logic do_write;
      logic [11:0] wa;
      do_write = 1'b0;
      wa = st.aw_addr;
      next_st = st;
      next_sk = sk;
      mem_we = 1'b0;
      mem_waddr = value_index(st.aw_addr);
      mem_raddr = 4'hF;

      // write channel: address and data taken in either order
      if (awvalid && st.awready)
      begin
         next_st.aw_held = 1'b1;
         next_st.aw_addr = awaddr;
         next_st.awready = 1'b0;
      end
      if (wvalid && st.wready)
      begin
         next_st.w_held = 1'b1;
         next_st.w_data = wdata;
         next_st.w_strb = wstrb;
         next_st.wready = 1'b0;
      end
      unique case (st.wst)
         PBCR_WR_IDLE:
         begin
            if (st.aw_held && st.w_held)
            begin
               do_write = 1'b1;
               next_st.wst = PBCR_WR_RESP;
               next_st.bvalid = 1'b1;
               next_st.bresp = `PBCR_RESP_OKAY;
            end
         end
         PBCR_WR_RESP:
         begin
            if (bready)
            begin
               next_st.bvalid = 1'b0;
               next_st.aw_held = 1'b0;
               next_st.w_held = 1'b0;
               next_st.awready = 1'b1;
               next_st.wready = 1'b1;
               next_st.wst = PBCR_WR_IDLE;
            end
         end
      endcase

      if (do_write)
      begin
         // header and flag writable only by the eeprom initialiser
         if (wa == `PBCR_OFF_CAP_HEADER)
         begin
            if (eeprom_init)
            begin
               next_st.header = merge(st.header, st.w_data, st.w_strb);
            end
         end
         else if (wa == `PBCR_OFF_DATA_SELECT)
         begin
            if (st.w_strb[0])
            begin
               next_st.selector = st.w_data[7:0];
            end
         end
         else if (wa == `PBCR_OFF_SYSTEM_ALLOC)
         begin
            if (eeprom_init && st.w_strb[0])
            begin
               next_sk.sys_alloc = st.w_data[0];
            end
         end
         else if (is_value_addr(wa))
         begin
            // locked writes are dropped but still answered okay
            mem_we = budget_value_unlock || eeprom_init;
         end
         else if (wa == `PBCR_OFF_DATA_WINDOW)
         begin
            next_st.bresp = `PBCR_RESP_OKAY;
         end
         else
         begin
            next_st.bresp = `PBCR_RESP_SLVERR;
         end
      end

      // read channel: one wait cycle for the registered memory read
      if (arvalid && st.arready)
      begin
         next_st.arready = 1'b0;
         next_st.rd_wait = 1'b1;
         next_st.rd_addr = araddr;
      end
      if (st.rd_wait)
      begin
         next_st.rd_wait = 1'b0;
         next_st.rvalid = 1'b1;
         next_st.rresp = `PBCR_RESP_OKAY;
         next_st.rdata = 32'h00000000;
         if (st.rd_addr == `PBCR_OFF_CAP_HEADER)
         begin
            next_st.rdata = st.header;
         end
         else if (st.rd_addr == `PBCR_OFF_DATA_SELECT)
         begin
            next_st.rdata = {24'h000000, st.selector};
         end
         else if (st.rd_addr == `PBCR_OFF_DATA_WINDOW)
         begin
            if (st.selector <= `PBCR_SEL_MAX)
            begin
               next_st.rdata = mem_rdata;
            end
            else
            begin
               next_st.rdata = 32'h00000000;
            end
         end
         else if (st.rd_addr == `PBCR_OFF_SYSTEM_ALLOC)
         begin
            next_st.rdata = {31'h00000000, sk.sys_alloc};
         end
         else if (is_value_addr(st.rd_addr))
         begin
            next_st.rdata = mem_rdata;
         end
         else
         begin
            next_st.rresp = `PBCR_RESP_SLVERR;
         end
      end
      if (st.rd_wait)
      begin
         if (st.rd_addr == `PBCR_OFF_DATA_WINDOW)
         begin
            mem_raddr = 4'hF;
         end
      end
      // memory address presented in the cycle the read is accepted
      if (arvalid && st.arready)
      begin
         if (araddr == `PBCR_OFF_DATA_WINDOW)
         begin
            mem_raddr = (st.selector <= `PBCR_SEL_MAX) ? st.selector[3:0] : 4'hF;
         end
         else if (is_value_addr(araddr))
         begin
            mem_raddr = value_index(araddr);
         end
      end
      if (st.rvalid && rready)
      begin
         next_st.rvalid = 1'b0;
         next_st.arready = 1'b1;
      end
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge aclk)
   begin
      if (!aresetn || !fund_resetn)
      begin
         st <= '0;
         st.header <= `PBCR_HEADER_RESET;
         st.selector <= `PBCR_SELECT_RESET;
         st.awready <= 1'b1;
         st.wready <= 1'b1;
         st.arready <= 1'b1;
         st.wst <= PBCR_WR_IDLE;
      end
      else
      begin
         st <= next_st;
      end
   end

   // flag cleared only by fundamental reset
   always_ff @(posedge aclk)
   begin
      if (!fund_resetn)
      begin
         sk <= '0;
      end
      else
      begin
         sk <= next_sk;
      end
   end

   assign awready = st.awready;
   assign wready = st.wready;
   assign bresp = st.bresp;
   assign bvalid = st.bvalid;
   assign arready = st.arready;
   assign rdata = st.rdata;
   assign rresp = st.rresp;
   assign rvalid = st.rvalid;
   assign system_allocated = sk.sys_alloc;
   assign value_selector = st.selector;
endmodule
`default_nettype wire

//--- verification/pbcr_regs_monitor.sv
// port checker for the power budget register bank
`timescale 1ns/10ps
`default_nettype none
`include "pbcr_map.svh"
module pbcr_regs_monitor
#(
   parameter int VALUE_COUNT = 10
)
(
   input wire logic aclk, // clock
   input wire logic aresetn, // hot reset
   input wire logic fund_resetn, // fundamental reset
   input wire logic awvalid, // aw valid
   input wire logic awready, // aw ready
   input wire logic wvalid, // w valid
   input wire logic wready, // w ready
   input wire logic [1:0] bresp, // b resp
   input wire logic bvalid, // b valid
   input wire logic bready, // b ready
   input wire logic [11:0] araddr, // ar addr
   input wire logic arvalid, // ar valid
   input wire logic arready, // ar ready
   input wire logic [31:0] rdata, // r data
   input wire logic [1:0] rresp, // r resp
   input wire logic rvalid, // r valid
   input wire logic rready, // r ready
   input wire logic system_allocated, // flag
   input wire logic [7:0] value_selector // selector
);
   logic [11:0] ar_q;
   logic [7:0] sel_q;
   logic map_q;
   // window answers with the selector seen when the read was taken
   always_ff @(posedge aclk)
   begin
      if (arvalid && arready)
      begin
         ar_q <= araddr;
         sel_q <= value_selector;
      end
   end
   assign map_q = (ar_q inside {12'h280, 12'h284, 12'h288, 12'h28C}) ||
      (ar_q >= 12'h300 && ar_q < 12'h300 + 12'(4 * VALUE_COUNT) && ar_q[1:0] == 2'b00);
   // ********************
   // properties
   // ********************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_write_latency: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
      else $error("write response late");
   a_read_latency: assert property (arvalid && arready |-> ##[2:3] rvalid)
      else $error("read response late");
   a_bvalid_once: assert property (bvalid && bready |=> !bvalid)
      else $error("second write response");
   a_write_busy: assert property (bvalid |-> !awready && !wready)
      else $error("write accepted while busy");
   a_read_busy: assert property (rvalid |-> !arready)
      else $error("read accepted while busy");
   a_resp_map: assert property (rvalid |-> rresp == (map_q ? `PBCR_RESP_OKAY : `PBCR_RESP_SLVERR))
      else $error("read response code wrong");
   a_window_zero: assert property (rvalid && ar_q == 12'h288 && sel_q > `PBCR_SEL_MAX |-> rdata == 32'h0)
      else $error("window not zero for large selector");
   a_sel_reset: assert property (@(posedge aclk) disable iff (!fund_resetn) !aresetn |=> value_selector == `PBCR_SELECT_RESET)
      else $error("selector not cleared by reset");
   a_flag_sticky: assert property (@(posedge aclk) disable iff (!fund_resetn) !aresetn |=> $stable(system_allocated))
      else $error("flag lost in hot reset");
   c_window_zero: cover property (rvalid && ar_q == 12'h288 && sel_q > `PBCR_SEL_MAX);
   c_unmapped: cover property (rvalid && !map_q);
   c_hot_flag: cover property (!aresetn && fund_resetn && system_allocated);
endmodule
`default_nettype wire

//--- verification/testbench.sv
// self-checking bench for the power budget register bank
`timescale 1ns/10ps
`default_nettype none
`include "pbcr_map.svh"
module testbench;
   logic aclk = 1'b0, aresetn = 1'b0, fund_resetn = 1'b0, budget_value_unlock = 1'b0;
   logic eeprom_init = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [31:0] wdata = 32'h0, rdata, data;
   logic awready, wready, bvalid, arready, rvalid, system_allocated;
   logic [1:0] bresp, rresp, resp;
   logic [7:0] value_selector;
   logic [3:0] wstrb = 4'hF;
   int error_cnt = 0, checks_done = 0;
   always #12.5 aclk = ~aclk;
   pbcr_regs i_dut (.aclk(aclk), .aresetn(aresetn), .fund_resetn(fund_resetn),
      .budget_value_unlock(budget_value_unlock), .eeprom_init(eeprom_init),
      .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .system_allocated(system_allocated), .value_selector(value_selector));
   // ********************
   // bus tasks
   // ********************
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e)
      begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      // no cycle count assumed: only the watchdog ends a stuck wait
      while (bvalid !== 1'b1)
      begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end
      resp = bresp;
      bready <= 1'b0;
      chk("bresp", 32'(resp), 32'(`PBCR_RESP_OKAY));
   endtask
   task automatic rd(input logic [11:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (rvalid !== 1'b1)
      begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end
      data = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] e);
      rd(a);
      chk("rresp", 32'(resp), 32'(`PBCR_RESP_OKAY));
      chk("rdata", data, e);
   endtask
   task automatic hit_reset(input logic fund);
      @(posedge aclk);
      aresetn <= 1'b0;
      fund_resetn <= !fund;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      fund_resetn <= 1'b1;
      @(posedge aclk);
   endtask
   // ********************
   // scenarios
   // ********************
   task automatic t_reset();
      rchk(12'h280, `PBCR_HEADER_RESET);
      rchk(12'h284, 32'h0);
      rchk(12'h28C, 32'h0);
      rd(12'h200);
      chk("rresp", 32'(resp), 32'(`PBCR_RESP_SLVERR));
      $display("test reset values done");
   endtask
   task automatic t_init();
      logic [31:0] h;
      h = {12'h000, `PBCR_CAPABILITY_VERSION_ONE, `PBCR_CAPABILITY_IDENTIFIER_POWER_BUDGET};
      wr(12'h280, h);
      wr(12'h28C, 32'h1);
      rchk(12'h280, 32'h0);
      rchk(12'h28C, 32'h0);
      eeprom_init <= 1'b1;
      wr(12'h280, h);
      wr(12'h28C, 32'h1);
      eeprom_init <= 1'b0;
      rchk(12'h280, h);
      rchk(12'h28C, 32'h1);
      chk("system_allocated", 32'(system_allocated), 32'h1);
      $display("test initialiser load done");
   endtask
   task automatic t_values();
      int i;
      budget_value_unlock <= 1'b1;
      for (i = 0; i < 10; i++) wr(12'h300 + 12'(4 * i), 32'hA5C30000 | i);
      budget_value_unlock <= 1'b0;
      wr(12'h30C, 32'h0BAD0BAD);
      wr(12'h288, 32'h12345678);
      rchk(12'h324, 32'hA5C30009);
      for (i = 0; i < 10; i++)
      begin
         wr(12'h284, i);
         rchk(12'h288, 32'hA5C30000 | i);
      end
      wr(12'h284, 32'h0000000A);
      chk("value_selector", 32'(value_selector), 32'hA);
      rchk(12'h288, 32'h0);
      wr(12'h284, 32'hFFFFFFFF);
      rchk(12'h284, 32'h000000FF);
      rchk(12'h288, 32'h0);
      $display("test value window done");
   endtask
   task automatic t_strobe();
      wr(12'h284, 32'h00000001);
      budget_value_unlock <= 1'b1;
      wstrb <= 4'h3;
      wr(12'h304, 32'h11112222);
      budget_value_unlock <= 1'b0;
      wstrb <= 4'hE;
      wr(12'h284, 32'h00000007);
      wstrb <= 4'hF;
      rchk(12'h284, 32'h00000001);
      rchk(12'h288, 32'hA5C32222);
      eeprom_init <= 1'b1;
      wr(12'h308, 32'h0000CAFE);
      eeprom_init <= 1'b0;
      rchk(12'h308, 32'h0000CAFE);
      rd(12'h302);
      chk("rresp", 32'(resp), 32'(`PBCR_RESP_SLVERR));
      $display("test byte strobes and initialiser values done");
   endtask
   task automatic t_sticky();
      wr(12'h284, 32'h5);
      hit_reset(1'b0);
      chk("value_selector", 32'(value_selector), 32'h0);
      chk("system_allocated", 32'(system_allocated), 32'h1);
      rchk(12'h288, 32'hA5C30000);
      hit_reset(1'b1);
      chk("system_allocated", 32'(system_allocated), 32'h0);
      $display("test sticky state done");
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial
   begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      fund_resetn <= 1'b1;
      t_reset();
      t_init();
      t_values();
      t_strobe();
      t_sticky();
      conclude();
   end
   // a hang stops the run well past the few hundred cycles of work
   initial
   begin
      repeat (20000) @(posedge aclk);
      error_cnt++;
      conclude();
   end
endmodule
bind pbcr_regs pbcr_regs_monitor #(.VALUE_COUNT(VALUE_COUNT)) i_mon (.aclk(aclk),
   .aresetn(aresetn), .fund_resetn(fund_resetn), .awvalid(awvalid), .awready(awready),
   .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
   .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
   .rvalid(rvalid), .rready(rready), .system_allocated(system_allocated),
   .value_selector(value_selector));
`default_nettype wire
